// *** logic/self_prog_flash_ctrl.sv ***
// Purpose: Self-programming sequencer for on-chip program flash
// Assumes: Core keeps store/load pulses one cycle wide
// Notes:   Flash array and lock bits are not cleared by reset
//
// What this block does
// - Store enable arms store for four cycles
// - Plain store loads word into page buffer
// - Store enable self-clears on completion or timeout
// - Store enable stays set while erase/write busy
// - Only five command patterns are accepted
// - EEPROM write blocks programming and fuse readback
// - Core checks EEPROM busy before control write
// - Pointer one returns lock bits on load
// - Readback bits self-clear after read or timeout
// - Pointer zero returns low fuse byte
// - Pointer three returns high fuse byte
// - Programmed bits read zero, unprogrammed one
// - Disarmed load reads program memory bytes
// - Flash writes last between 3.7 and 4.5 ms
// - Reset does not abort a started write
// - Two lock bits, erased only by chip erase
// - Lock mode two blocks external programming
// - Lock mode three blocks program and verify
// - Debug fuse keeps memory readable over debug
// - Program fuses before any lock bit
// - Page address from upper pointer bits only
// - Core stalled during erase or write
`timescale 1ns/1ps
module self_prog_flash_ctrl #(
    parameter int PAGE_WORDS = 32,
    parameter int NUM_PAGES  = 128,
    parameter int WR_CYC     = sp_pkg::FLASH_WR_CYC
) (
    // Clock and reset
    input  wire logic       I_CLK,
    input  wire logic       I_RST_N,
    // Core link
    sp_link_if.dev          link,
    // Fuse bytes as read, programmed bits at zero
    input  wire logic [7:0] I_FUSE_LOW,
    input  wire logic [7:0] I_FUSE_HIGH,
    // External chip erase strobe
    input  wire logic       I_CHIP_ERASE,
    // Protection status
    output logic            O_EXT_PROG_BLOCK,
    output logic            O_EXT_VERIFY_BLOCK,
    output logic            O_FUSE_FREEZE,
    output logic            O_DEBUG_LINK_OFF,
    output logic            O_DEBUG_MEM_READ,
    output logic            O_FLASH_BUSY
);
    localparam int NUM_WORDS = PAGE_WORDS * NUM_PAGES;
    localparam int WB        = $clog2(PAGE_WORDS);
    localparam int AW        = $clog2(NUM_WORDS);
    localparam int CW        = $clog2(WR_CYC + 1);

    // ----------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------
    function automatic logic valid_cmd(input logic [4:0] c);
        valid_cmd = (c == sp_pkg::CMD_LOAD)  ||
                    (c == sp_pkg::CMD_ERASE) ||
                    (c == sp_pkg::CMD_WRITE) ||
                    (c == sp_pkg::CMD_READ)  ||
                    (c == sp_pkg::CMD_CLEAR);
    endfunction

    // ----------------------------------------------------------
    // State
    // ----------------------------------------------------------
    logic [4:0]    ctrl_ff;
    logic [2:0]    win_ff;
    logic          busy_ff;
    logic [CW-1:0] busy_cnt_ff;
    logic [7:0]    load_data_ff;
    logic          load_valid_ff;
    // Non-volatile: power-up value only, reset leaves it alone
    logic [1:0]    lock_ff = sp_pkg::LOCK_RESET;
    logic [15:0]   pbuf [PAGE_WORDS];
    logic [15:0]   flash [NUM_WORDS];

    logic          cr_ok;
    logic          store_go;
    logic          long_op;
    logic          load_rd;
    logic          busy_end;
    logic [AW-1:0] page_base;
    logic [AW-1:0] word_addr;
    logic [WB-1:0] buf_addr;
    logic [15:0]   rd_word;
    logic [7:0]    fuse_byte;

    // Writes during busy or EEPROM write are dropped
    assign cr_ok = link.cr_wr && !busy_ff && !link.ee_busy &&
                   valid_cmd(link.cr_wdata[4:0]);
    assign store_go = link.store_insn && (win_ff != 3'h0) &&
                      !busy_ff && !link.ee_busy;
    assign long_op = store_go &&
                     (ctrl_ff == sp_pkg::CMD_ERASE ||
                      ctrl_ff == sp_pkg::CMD_WRITE ||
                      ctrl_ff == sp_pkg::CMD_READ);
    assign load_rd = link.load_insn && !link.ee_busy &&
                     (ctrl_ff == sp_pkg::CMD_READ) &&
                     (win_ff >= sp_pkg::LOAD_MIN_LEFT);
    assign busy_end = busy_ff && (busy_cnt_ff == CW'(1));

    // Register pair ignored, page from upper pointer bits
    assign page_base = {link.zptr[AW:WB+1], {WB{1'b0}}};
    assign word_addr = link.zptr[AW:1];
    assign buf_addr  = link.zptr[WB:1];
    assign rd_word   = flash[word_addr];

    always_comb begin
        unique case (link.zptr)
            sp_pkg::Z_FUSE_LOW:  fuse_byte = I_FUSE_LOW;
            sp_pkg::Z_LOCK:
                fuse_byte = {sp_pkg::LOCK_UNUSED,
                             lock_ff};
            sp_pkg::Z_FUSE_HIGH: fuse_byte = I_FUSE_HIGH;
            default:             fuse_byte = sp_pkg::NO_FUSE;
        endcase
    end

    // ----------------------------------------------------------
    // Control register and arming window
    // ----------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ctrl_ff <= sp_pkg::CR_RESET;
            win_ff  <= 3'h0;
        end else if (cr_ok) begin
            ctrl_ff <= link.cr_wdata[4:0];
            win_ff  <= sp_pkg::STORE_WIN;
        end else if (busy_ff) begin
            // Bits stay up as the busy flag
            win_ff <= 3'h0;
            if (busy_end) begin
                ctrl_ff <= sp_pkg::CR_RESET;
            end
        end else if (long_op) begin
            win_ff <= 3'h0;
        end else if (store_go || load_rd) begin
            ctrl_ff <= sp_pkg::CR_RESET;
            win_ff  <= 3'h0;
        end else if (win_ff == 3'h1) begin
            ctrl_ff <= sp_pkg::CR_RESET;
            win_ff  <= 3'h0;
        end else if (win_ff != 3'h0) begin
            win_ff <= win_ff - 3'h1;
        end
    end

    // ----------------------------------------------------------
    // Flash write timer and core stall
    // ----------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            busy_ff     <= 1'b0;
            busy_cnt_ff <= '0;
        end else if (long_op) begin
            busy_ff     <= 1'b1;
            busy_cnt_ff <= CW'(WR_CYC);
        end else if (busy_ff) begin
            busy_cnt_ff <= busy_cnt_ff - CW'(1);
            if (busy_end) begin
                busy_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------
    // Temporary page buffer
    // ----------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            for (int i = 0; i < PAGE_WORDS; i++) begin
                pbuf[i] <= sp_pkg::ERASED_WORD;
            end
        end else if (store_go && (ctrl_ff == sp_pkg::CMD_LOAD)) begin
            pbuf[buf_addr] <= link.word_pair;
        end else if (store_go && (ctrl_ff == sp_pkg::CMD_CLEAR ||
                                  ctrl_ff == sp_pkg::CMD_WRITE)) begin
            for (int i = 0; i < PAGE_WORDS; i++) begin
                pbuf[i] <= sp_pkg::ERASED_WORD;
            end
        end
    end

    // ----------------------------------------------------------
    // Flash array
    // ----------------------------------------------------------
    // Committed at the start so a reset during the timed
    // period cannot leave a half-written page
    always_ff @(posedge I_CLK) begin
        if (long_op && ctrl_ff == sp_pkg::CMD_ERASE) begin
            for (int i = 0; i < PAGE_WORDS; i++) begin
                flash[page_base + AW'(i)] <=
                    sp_pkg::ERASED_WORD;
            end
        end else if (long_op && ctrl_ff == sp_pkg::CMD_WRITE) begin
            for (int i = 0; i < PAGE_WORDS; i++) begin
                flash[page_base + AW'(i)] <= pbuf[i];
            end
        end
    end

    // ----------------------------------------------------------
    // Lock bits
    // ----------------------------------------------------------
    // Store can only program bits to zero
    always_ff @(posedge I_CLK) begin
        if (I_CHIP_ERASE) begin
            lock_ff <= sp_pkg::LOCK_RESET;
        end else if (long_op && ctrl_ff == sp_pkg::CMD_READ) begin
            lock_ff <= lock_ff & link.word_pair[1:0];
        end
    end

    // ----------------------------------------------------------
    // Load path
    // ----------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            load_data_ff  <= 8'h00;
            load_valid_ff <= 1'b0;
        end else begin
            load_valid_ff <= link.load_insn;
            if (load_rd) begin
                load_data_ff <= fuse_byte;
            end else if (link.load_insn) begin
                load_data_ff <= link.zptr[0] ? rd_word[15:8]
                                             : rd_word[7:0];
            end
        end
    end

    // ----------------------------------------------------------
    // Protection outputs
    // ----------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_EXT_PROG_BLOCK   <= 1'b0;
            O_EXT_VERIFY_BLOCK <= 1'b0;
            O_FUSE_FREEZE      <= 1'b0;
            O_DEBUG_LINK_OFF   <= 1'b0;
            O_DEBUG_MEM_READ   <= 1'b0;
        end else begin
            O_EXT_PROG_BLOCK   <= !lock_ff[0];
            O_EXT_VERIFY_BLOCK <= (lock_ff == 2'h0);
            O_FUSE_FREEZE      <= !lock_ff[0];
            O_DEBUG_LINK_OFF   <= !lock_ff[0];
            // Programmed debug fuse bypasses lock protection
            O_DEBUG_MEM_READ   <=
                !I_FUSE_HIGH[sp_pkg::DEBUG_FUSE_BIT];
        end
    end

    assign O_FLASH_BUSY    = busy_ff;
    assign link.stall      = busy_ff;
    assign link.cr_rdata   = {3'h0, ctrl_ff};
    assign link.load_data  = load_data_ff;
    assign link.load_valid = load_valid_ff;
endmodule

// *** logic/sp_core_end.sv ***
// Purpose: Core-side driver of the flash sequencer link, APB slave
// Assumes: APB with one wait state per transfer
// Notes:   Issues control write and instruction back to back
`timescale 1ns/1ps
module sp_core_end (
    // Clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RST_N,
    // APB slave
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    // Sequencer link
    sp_link_if.core          link
);
    typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_INSN, ST_WAIT} st_t;

    st_t         st_ff;
    logic [7:0]  cr_data_ff;
    logic [15:0] z_ff;
    logic [15:0] word_ff;
    logic        ee_ff;
    logic [2:0]  op_ff;
    logic [7:0]  result_ff;
    logic        refused_ff;
    logic        cr_wr_ff;
    logic        store_ff;
    logic        load_ff;
    logic        acc;
    logic        wr_done;
    logic        op_go;
    logic        mapped;
    logic [31:0] rd_mux;

    assign acc     = I_PSEL && I_PENABLE;
    assign wr_done = acc && O_PREADY && I_PWRITE && mapped;
    assign op_go   = wr_done && (I_PADDR == sp_pkg::REG_OP) &&
                     (st_ff == ST_IDLE);

    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (I_PADDR)
            sp_pkg::REG_CR_DATA: rd_mux = {24'h0, cr_data_ff};
            sp_pkg::REG_ZPTR:    rd_mux = {16'h0, z_ff};
            sp_pkg::REG_WORD:    rd_mux = {16'h0, word_ff};
            sp_pkg::REG_OP:      rd_mux = {29'h0, op_ff};
            sp_pkg::REG_STATUS:
                rd_mux = {12'h0, ee_ff, refused_ff, link.stall,
                          st_ff != ST_IDLE, link.cr_rdata, result_ff};
            sp_pkg::REG_EE:      rd_mux = {31'h0, ee_ff};
            default:             mapped = 1'b0;
        endcase
    end

    // ----------------------------------------------------------
    // APB handshake, one wait state
    // ----------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_PREADY  <= 1'b0;
            O_PRDATA  <= 32'h0000_0000;
            O_PSLVERR <= 1'b0;
        end else if (acc && !O_PREADY) begin
            O_PREADY  <= 1'b1;
            O_PRDATA  <= I_PWRITE ? 32'h0000_0000 : rd_mux;
            O_PSLVERR <= !mapped;
        end else begin
            O_PREADY  <= 1'b0;
            O_PSLVERR <= 1'b0;
        end
    end

    // ----------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            cr_data_ff <= 8'h00;
            z_ff       <= 16'h0000;
            word_ff    <= 16'h0000;
            ee_ff      <= 1'b0;
            op_ff      <= 3'h0;
        end else if (wr_done) begin
            unique case (I_PADDR)
                sp_pkg::REG_CR_DATA: cr_data_ff <= I_PWDATA[7:0];
                sp_pkg::REG_ZPTR:    z_ff <= I_PWDATA[15:0];
                sp_pkg::REG_WORD:    word_ff <= I_PWDATA[15:0];
                sp_pkg::REG_OP: begin
                    if (st_ff == ST_IDLE) begin
                        op_ff <= I_PWDATA[2:0];
                    end
                end
                sp_pkg::REG_EE:      ee_ff <= I_PWDATA[0];
                default:             ee_ff <= ee_ff;
            endcase
        end
    end

    // ----------------------------------------------------------
    // Sequencer: control write, then instruction next cycle
    // ----------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            st_ff      <= ST_IDLE;
            cr_wr_ff   <= 1'b0;
            store_ff   <= 1'b0;
            load_ff    <= 1'b0;
            refused_ff <= 1'b0;
            result_ff  <= 8'h00;
        end else begin
            cr_wr_ff <= 1'b0;
            store_ff <= 1'b0;
            load_ff  <= 1'b0;
            if (link.load_valid) begin
                result_ff <= link.load_data;
            end
            unique case (st_ff)
                ST_IDLE: begin
                    if (op_go && I_PWDATA[sp_pkg::OP_CR_BIT]) begin
                        // Control write refused while EEPROM busy, op dropped
                        refused_ff <= ee_ff;
                        cr_wr_ff   <= !ee_ff;
                        st_ff      <= ee_ff ? ST_IDLE : ST_ISSUE;
                    end else if (op_go) begin
                        refused_ff <= 1'b0;
                        st_ff      <= ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    // One cycle after the write, inside every window
                    store_ff <= op_ff[sp_pkg::OP_STORE_BIT];
                    load_ff  <= op_ff[sp_pkg::OP_LOAD_BIT] &&
                                !op_ff[sp_pkg::OP_STORE_BIT];
                    st_ff    <= ST_INSN;
                end
                ST_INSN: st_ff <= ST_WAIT;
                ST_WAIT: begin
                    if (!link.stall) begin
                        st_ff <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign link.cr_wr      = cr_wr_ff;
    assign link.cr_wdata   = cr_data_ff;
    assign link.store_insn = store_ff;
    assign link.load_insn  = load_ff;
    assign link.zptr       = z_ff;
    assign link.word_pair  = word_ff;
    assign link.ee_busy    = ee_ff;
endmodule

// *** logic/sp_link_if.sv ***
// Purpose: Link between processor core and flash sequencer
// Assumes: Both ends on the same clock
// Notes:   Pulses are one cycle wide
`timescale 1ns/1ps
interface sp_link_if;
    logic        cr_wr;
    logic [7:0]  cr_wdata;
    logic [7:0]  cr_rdata;
    logic        store_insn;
    logic        load_insn;
    logic [15:0] zptr;
    logic [15:0] word_pair;
    logic        ee_busy;
    logic [7:0]  load_data;
    logic        load_valid;
    logic        stall;

    modport dev (
        input  cr_wr, cr_wdata, store_insn, load_insn, zptr,
        input  word_pair, ee_busy,
        output cr_rdata, load_data, load_valid, stall
    );
    modport core (
        output cr_wr, cr_wdata, store_insn, load_insn, zptr,
        output word_pair, ee_busy,
        input  cr_rdata, load_data, load_valid, stall
    );
endinterface

// *** logic/sp_pkg.sv ***
// Purpose: Shared constants for the self-programming flash link
// Assumes: 100 MHz core clock
// Notes:   Host register map belongs to the core end
package sp_pkg;
    // ----------------------------------------------------------
    // Control register layout
    // ----------------------------------------------------------
    localparam int        CR_W          = 5;
    localparam int        STORE_EN_BIT  = 0;
    localparam int        ERASE_BIT     = 1;
    localparam int        WRITE_BIT     = 2;
    localparam int        FUSE_RD_BIT   = 3;
    localparam int        CLEAR_BIT     = 4;
    localparam logic [4:0] CMD_LOAD     = 5'h01;
    localparam logic [4:0] CMD_ERASE    = 5'h03;
    localparam logic [4:0] CMD_WRITE    = 5'h05;
    localparam logic [4:0] CMD_READ     = 5'h09;
    localparam logic [4:0] CMD_CLEAR    = 5'h11;
    localparam logic [4:0] CR_RESET     = 5'h00;
    // ----------------------------------------------------------
    // Arming windows, in cycles after the control write
    // ----------------------------------------------------------
    localparam logic [2:0] STORE_WIN    = 3'h4;
    localparam logic [2:0] LOAD_WIN     = 3'h3;
    localparam logic [2:0] LOAD_MIN_LEFT = STORE_WIN - LOAD_WIN + 3'h1;
    // ----------------------------------------------------------
    // Flash write timing
    // ----------------------------------------------------------
    localparam real       FLASH_WR_MIN_MS = 3.7;
    localparam real       FLASH_WR_MAX_MS = 4.5;
    localparam real       CLK_MHZ       = 100.0;
    localparam int        FLASH_WR_CYC  =
        int'($ceil(FLASH_WR_MIN_MS * 1000.0 * CLK_MHZ));
    // ----------------------------------------------------------
    // Readback pointers and lock byte
    // ----------------------------------------------------------
    localparam logic [15:0] Z_FUSE_LOW  = 16'h0000;
    localparam logic [15:0] Z_LOCK      = 16'h0001;
    localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
    localparam logic [1:0]  LOCK_RESET  = 2'h3;
    localparam logic [5:0]  LOCK_UNUSED = 6'h3f;
    localparam logic [7:0]  NO_FUSE     = 8'hff;
    localparam int          DEBUG_FUSE_BIT = 6;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    // ----------------------------------------------------------
    // Core end APB map
    // ----------------------------------------------------------
    localparam logic [7:0] REG_CR_DATA  = 8'h00;
    localparam logic [7:0] REG_ZPTR     = 8'h04;
    localparam logic [7:0] REG_WORD     = 8'h08;
    localparam logic [7:0] REG_OP       = 8'h0c;
    localparam logic [7:0] REG_STATUS   = 8'h10;
    localparam logic [7:0] REG_EE       = 8'h14;
    localparam int         OP_CR_BIT    = 0;
    localparam int         OP_STORE_BIT = 1;
    localparam int         OP_LOAD_BIT  = 2;
endpackage

// *** verification/self_prog_flash_ctrl_tb_top.sv ***
// Purpose: Self-checking bench, APB master on the core end
// Assumes: Flash write shortened to WR cycles
// Notes:   Fuse bytes tied to fixed patterns
`timescale 1ns/1ps
module self_prog_flash_ctrl_tb_top;
    localparam int         WR  = 20;
    localparam logic [7:0] FLO = 8'h62;
    localparam logic [7:0] FHI = 8'h9f;
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, chip = 1'b0, pready, pslverr, perr;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        ext_prog, ext_ver, fz, dbg_off, dbg_rd, fbusy;
    int          failures = 0, cmp_count = 0;
    logic [15:0] rz [4] = '{16'h0000, 16'h0003, 16'h0001, 16'h0002};
    logic [7:0]  rx [4] = '{FLO, FHI, 8'hff, 8'hff};
    // ----------------------------------------------------------
    // Both ends and the checker
    // ----------------------------------------------------------
    sp_link_if i_sp_link_if ();
    sp_core_end i_sp_core_end (.I_CLK(clk), .I_RST_N(rst_n),
        .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .link(i_sp_link_if));
    self_prog_flash_ctrl #(.WR_CYC(WR)) i_self_prog_flash_ctrl (
        .I_CLK(clk), .I_RST_N(rst_n), .link(i_sp_link_if),
        .I_FUSE_LOW(FLO), .I_FUSE_HIGH(FHI), .I_CHIP_ERASE(chip),
        .O_EXT_PROG_BLOCK(ext_prog), .O_EXT_VERIFY_BLOCK(ext_ver),
        .O_FUSE_FREEZE(fz), .O_DEBUG_LINK_OFF(dbg_off),
        .O_DEBUG_MEM_READ(dbg_rd), .O_FLASH_BUSY(fbusy));
    sp_link_chk #(.WR_CYC(WR)) i_sp_link_chk (.I_CLK(clk),
        .I_RST_N(rst_n), .cr_wr(i_sp_link_if.cr_wr),
        .cr_wdata(i_sp_link_if.cr_wdata), .cr_rdata(i_sp_link_if.cr_rdata),
        .store_insn(i_sp_link_if.store_insn),
        .load_insn(i_sp_link_if.load_insn), .ee_busy(i_sp_link_if.ee_busy),
        .load_valid(i_sp_link_if.load_valid), .stall(i_sp_link_if.stall));
    always #5 clk = ~clk;
    // ----------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------
    task automatic chk(input logic [31:0] got, exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        perr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic issue(input logic [7:0] cr, input logic [15:0] z,
                         input logic [3:0] o);
        logic [31:0] r;
        apb(1'b1, sp_pkg::REG_ZPTR, {16'h0000, z}, r);
        apb(1'b1, sp_pkg::REG_CR_DATA, {24'h000000, cr}, r);
        apb(1'b1, sp_pkg::REG_OP, {28'h0000000, o}, r);
    endtask
    task automatic op(input logic [7:0] cr, input logic [15:0] z,
                      input logic [3:0] o, output logic [31:0] st);
        issue(cr, z, o);
        st = 32'h00010000;
        while (st[16] !== 1'b0) apb(1'b0, sp_pkg::REG_STATUS, 32'h0, st);
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #200000;
        failures++;
        $display("BAD %0t watchdog expired", $time);
        stop_test();
    end
    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        logic [31:0] st;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            op(8'h09, rz[i], 4'h5, st);
            chk(st[15:0], {8'h00, rx[i]}, "readback");
        end
        $display("readback table done");
        op(8'h03, 16'h0040, 4'h3, st);
        apb(1'b1, sp_pkg::REG_WORD, 32'h00001234, st);
        op(8'h01, 16'h0043, 4'h3, st);
        issue(8'h05, 16'h0040, 4'h3);
        repeat (5) @(posedge clk);
        chk({29'h0, i_sp_link_if.stall, fbusy, i_sp_link_if.cr_rdata[0]},
            32'h7, "busy");
        rst_n <= 1'b0;
        @(posedge clk);
        chk({30'h0, i_sp_link_if.stall, fbusy}, 32'h0, "reset");
        rst_n <= 1'b1;
        op(8'h00, 16'h0042, 4'h4, st);
        chk({24'h0, st[7:0]}, 32'h34, "low byte");
        op(8'h00, 16'h0043, 4'h4, st);
        chk({24'h0, st[7:0]}, 32'h12, "high byte");
        $display("page program done");
        apb(1'b1, sp_pkg::REG_WORD, 32'h0000fffe, st);
        op(8'h09, 16'h0001, 4'h3, st);
        chk({27'h0, ext_prog, ext_ver, fz, dbg_off, dbg_rd}, 32'h17,
            "mode two");
        op(8'h09, 16'h0001, 4'h5, st);
        chk({24'h0, st[7:0]}, 32'hfe, "lock read");
        apb(1'b1, sp_pkg::REG_WORD, 32'h0000fffc, st);
        op(8'h09, 16'h0001, 4'h3, st);
        chk({27'h0, ext_prog, ext_ver, fz, dbg_off, dbg_rd}, 32'h1f,
            "mode three");
        @(posedge clk);
        chip <= 1'b1;
        @(posedge clk);
        chip <= 1'b0;
        op(8'h09, 16'h0001, 4'h5, st);
        chk({19'h0, ext_prog, ext_ver, fz, dbg_off, dbg_rd, st[7:0]},
            32'h1ff, "chip erase");
        $display("lock test done");
        apb(1'b1, sp_pkg::REG_EE, 32'h1, st);
        op(8'h09, 16'h0000, 4'h5, st);
        chk({30'h0, st[19:18]}, 32'h3, "ee refusal");
        apb(1'b1, sp_pkg::REG_EE, 32'h0, st);
        op(8'h01, 16'h0000, 4'h1, st);
        apb(1'b0, sp_pkg::REG_STATUS, 32'h0, st);
        chk({24'h0, st[15:8]}, 32'h0, "window");
        op(8'h07, 16'h0000, 4'h1, st);
        apb(1'b0, sp_pkg::REG_STATUS, 32'h0, st);
        chk({24'h0, st[15:8]}, 32'h0, "bad command");
        apb(1'b0, 8'h20, 32'h0, st);
        chk({31'h0, perr}, 32'h1, "unmapped");
        $display("refusal test done");
        stop_test();
    end
endmodule

// *** verification/sp_link_chk.sv ***
// Purpose: Link checker between core end and flash sequencer
// Assumes: One clock domain, reset async active low
// Notes:   WR_CYC must match the sequencer instance
`timescale 1ns/1ps
module sp_link_chk #(
    parameter int WR_CYC = 20
) (
    // Clock and reset
    input wire logic       I_CLK,
    input wire logic       I_RST_N,
    // Link signals
    input wire logic       cr_wr,
    input wire logic [7:0] cr_wdata,
    input wire logic [7:0] cr_rdata,
    input wire logic       store_insn,
    input wire logic       load_insn,
    input wire logic       ee_busy,
    input wire logic       load_valid,
    input wire logic       stall
);
    // ----------------------------------------------------------
    // Stall length counter and properties
    // ----------------------------------------------------------
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    int unsigned stall_cnt_ff;
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            stall_cnt_ff <= 0;
        end else if (stall) begin
            stall_cnt_ff <= stall_cnt_ff + 1;
        end else begin
            stall_cnt_ff <= 0;
        end
    end
    a_load_answer: assert property (
        load_insn |=> load_valid) else $error("load not answered");
    a_answer_cause: assert property (
        load_valid |-> $past(load_insn)) else $error("stray answer");
    a_cmd_accepted: assert property (
        cr_wr && !ee_busy && !stall && cr_rdata == 8'h00 &&
        cr_wdata[4:0] inside {5'h01, 5'h03, 5'h05, 5'h09, 5'h11}
        |=> cr_rdata[4:0] == $past(cr_wdata[4:0]))
        else $error("command not taken");
    a_bad_cmd_ignored: assert property (
        cr_wr && cr_rdata == 8'h00 &&
        !(cr_wdata[4:0] inside {5'h01, 5'h03, 5'h05, 5'h09, 5'h11})
        |=> cr_rdata == 8'h00) else $error("bad command took effect");
    a_arm_expires: assert property (
        $rose(cr_rdata[0]) |-> ##[0:4] (!cr_rdata[0] || stall))
        else $error("arming window too long");
    a_busy_holds_enable: assert property (
        stall |-> cr_rdata[0]) else $error("enable dropped while busy");
    a_stall_length: assert property (
        $fell(stall) |-> stall_cnt_ff == WR_CYC)
        else $error("flash write length wrong");
    a_ee_blocks: assert property (
        ee_busy && !stall && cr_rdata == 8'h00
        |=> !stall && cr_rdata == 8'h00) else $error("ee write not blocking");
    a_store_clears: assert property (
        cr_rdata[4:0] == 5'h01 && store_insn && !ee_busy
        |=> !cr_rdata[0]) else $error("enable kept after store");
    a_readback_clears: assert property (
        cr_rdata[3] && load_insn && !ee_busy && !stall
        |=> !cr_rdata[3]) else $error("readback bits kept");
endmodule
